//--- include/flic_pkg.sv
// Constants and types for the four-level interrupt controller
package flic_pkg;

  // ****************************************
  // Clocking
  // ****************************************
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned MC_CLKS     = 4;
  localparam int unsigned CALL_MC     = 4;
  localparam logic [1:0]  MC_LAST     = 2'(MC_CLKS - 1);
  localparam logic [1:0]  CALL_LAST   = 2'(CALL_MC - 1);

  // ****************************************
  // Sources in arbitration ranking order
  // ****************************************
  localparam int unsigned NSRC        = 11;
  localparam int unsigned SRC_EXT0    = 0;
  localparam int unsigned SRC_BO      = 1;
  localparam int unsigned SRC_WDT     = 2;
  localparam int unsigned SRC_TMR0    = 3;
  localparam int unsigned SRC_I2C     = 4;
  localparam int unsigned SRC_EXT1    = 5;
  localparam int unsigned SRC_KB      = 6;
  localparam int unsigned SRC_TMR1    = 7;
  localparam int unsigned SRC_UART    = 8;
  localparam int unsigned SRC_T2      = 9;
  localparam int unsigned SRC_CAP     = 10;

  localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033,
                                         16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0043,
                                         16'h006B};

  localparam logic [NSRC-1:0] WAKE_MASK = 11'h067;

  // ****************************************
  // Enable register bit positions
  // ****************************************
  localparam int unsigned ENA_EXT0    = 0;
  localparam int unsigned ENA_TMR0    = 1;
  localparam int unsigned ENA_EXT1    = 2;
  localparam int unsigned ENA_TMR1    = 3;
  localparam int unsigned ENA_UART    = 4;
  localparam int unsigned ENA_T2      = 5;
  localparam int unsigned ENA_GLOBAL  = 7;
  localparam int unsigned ENB_I2C     = 0;
  localparam int unsigned ENB_KB      = 1;
  localparam int unsigned ENB_WDT     = 4;
  localparam int unsigned ENB_BO      = 6;
  localparam int unsigned ENB_CAP     = 7;
  localparam logic [7:0]  EN_RESET    = 8'h00;

  // ****************************************
  // Flag vector bit positions
  // ****************************************
  localparam int unsigned NFLG        = 10;
  localparam int unsigned FLG_TMR0    = 0;
  localparam int unsigned FLG_TMR1    = 1;
  localparam int unsigned FLG_WDT     = 2;
  localparam int unsigned FLG_T2      = 3;
  localparam int unsigned FLG_RX      = 4;
  localparam int unsigned FLG_TX      = 5;
  localparam int unsigned FLG_SI      = 6;
  localparam int unsigned FLG_I2CTO   = 7;
  localparam int unsigned FLG_CAP     = 8;
  localparam int unsigned FLG_KB      = 9;

  typedef logic [1:0] flic_lvl_t;
  typedef logic [3:0] flic_src_t;
  typedef enum logic {FLIC_IDLE, FLIC_CALL} flic_state_e;

endpackage : flic_pkg

//--- rtl/flic_core.sv
// Four-level prioritized interrupt controller with hardware call sequencing
`timescale 1ns/1ps

// What this block does
// RQ1 - Eleven sources, each with flag, enable, priority and vector; global enable gates all.
// RQ2 - Edge mode: sample pins each machine cycle, high then low sets external flag.
// RQ3 - Edge mode: external flag cleared when its hardware call is made.
// RQ4 - Level mode: pin held low by source; flag not cleared on entry.
// RQ5 - Timer0/timer1 flags set on overflow, cleared when their call is made.
// RQ6 - Watchdog flag set on time-out, requests only when enabled, software clears.
// RQ7 - Timer2 flag set on overflow or match, not cleared on entry.
// RQ8 - UART request is receive OR transmit flag; only software clears them.
// RQ9 - I2C flag set on new state code; requests need global and I2C enable.
// RQ10 - Capture flag set per event, kept on entry; capture and keypad software-cleared.
// RQ11 - Brownout requests only with flag, select, enable and global enable all set.
// RQ12 - Granted call loads the program counter with the source's fixed vector.
// RQ13 - Flags sampled every machine cycle, then polled and priority resolved.
// RQ14 - Call only if no equal/higher level active, last cycle, no blocking instruction.
// RQ15 - Denied requests are not remembered; every poll starts fresh.
// RQ16 - Hardware call pushes the program counter only, never the status word.
// RQ17 - Interrupt return pops and ends service level; plain return only pops.
// RQ18 - Two priority bits per source select levels 0 to 3.
// RQ19 - Only a strictly higher level preempts; level 3 never preempted.
// RQ20 - Same-level ties resolved by fixed ranking, external 0 first.
// RQ21 - Per-source enable bits in two enable registers; global bit disables all.
// RQ22 - Only external 0/1, brownout, watchdog and keypad wake from power-down.
// RQ23 - Hardware call sequence lasts four machine cycles.
// RQ24 - Level mode: external flag simply follows the sampled pin.
// RQ25 - Reset clears enables, priorities and in-service tracking.
module flic_core (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic [1:0]                 ext_irq_n,
  input  wire logic [1:0]                 ext_trigger_select,
  input  wire logic                       timer0_ovf,
  input  wire logic                       timer1_ovf,
  input  wire logic                       wdt_timeout,
  input  wire logic                       timer2_event,
  input  wire logic                       uart_rx_done,
  input  wire logic                       uart_tx_done,
  input  wire logic [7:0]                 i2c_state_code,
  input  wire logic                       i2c_timeout,
  input  wire logic                       capture_event,
  input  wire logic                       keypad_event,
  input  wire logic                       brownout_flag,
  input  wire logic                       brownout_irq_select,
  input  wire logic [flic_pkg::NFLG-1:0]  flag_sw_clear,
  input  wire logic [7:0]                 irq_enable_reg_a,
  input  wire logic [7:0]                 irq_enable_reg_b,
  input  wire logic [flic_pkg::NSRC-1:0]  priority_upper_bit,
  input  wire logic [flic_pkg::NSRC-1:0]  priority_lower_bit,
  input  wire logic                       last_cycle,
  input  wire logic                       instr_blocks,
  input  wire logic                       return_from_irq,
  input  wire logic                       subr_return,
  output logic [1:0]                      ext_request_flag,
  output logic [flic_pkg::NFLG-1:0]       irq_flags,
  output logic                            mc_tick,
  output logic                            call_busy,
  output logic                            push_pc,
  output logic                            load_pc,
  output logic [15:0]                     vector_addr,
  output logic [3:0]                      call_src,
  output logic [3:0]                      in_service,
  output logic                            pop_pc,
  output logic                            wake_req
);
  import flic_pkg::*;

  // ****************************************
  // Machine cycle divider
  // ****************************************
  logic [1:0] div_q;
  logic       tick_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == MC_LAST) ? 2'h0 : div_q + 2'h1;
      tick_q <= (div_q == MC_LAST);
    end
  end
  assign mc_tick = tick_q;

  // ****************************************
  // Configuration capture
  // ****************************************
  logic [7:0]      en_a_q;
  logic [7:0]      en_b_q;
  logic [NSRC-1:0] pu_q;
  logic [NSRC-1:0] pl_q;
  logic [1:0]      trig_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_a_q <= EN_RESET;  // [RQ25]
      en_b_q <= EN_RESET;  // [RQ25]
      pu_q   <= '0;        // [RQ25]
      pl_q   <= '0;        // [RQ25]
      trig_q <= 2'h0;
    end else begin
      en_a_q <= irq_enable_reg_a;
      en_b_q <= irq_enable_reg_b;
      pu_q   <= priority_upper_bit;
      pl_q   <= priority_lower_bit;
      trig_q <= ext_trigger_select;
    end
  end

  // ****************************************
  // External pins
  // ****************************************
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] samp_q;
  logic [1:0] ext_q;
  logic       grant;
  flic_src_t  best_idx;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      samp_q  <= 2'h3;
    end else begin
      sync1_q <= ext_irq_n;
      sync2_q <= sync1_q;
      if (tick_q) begin
        samp_q <= sync2_q;
      end
    end
  end

  for (genvar e = 0; e < 2; e++) begin : g_ext
    localparam flic_src_t SRC_ID = (e == 0) ? flic_src_t'(SRC_EXT0) : flic_src_t'(SRC_EXT1);
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        ext_q[e] <= 1'b0;
      end else if (!trig_q[e]) begin
        if (tick_q) begin
          ext_q[e] <= ~sync2_q[e];  // [RQ24] [RQ4]
        end
      end else if (tick_q && samp_q[e] && !sync2_q[e]) begin
        ext_q[e] <= 1'b1;  // [RQ2]
      end else if (grant && best_idx == SRC_ID) begin
        ext_q[e] <= 1'b0;  // [RQ3]
      end
    end
  end
  assign ext_request_flag = ext_q;

  // ****************************************
  // Peripheral flags
  // ****************************************
  logic [7:0]      code_q;
  logic [NFLG-1:0] flg_q;
  logic [NFLG-1:0] set_vec;
  logic [NFLG-1:0] hw_clr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      code_q <= 8'h00;
    end else begin
      code_q <= i2c_state_code;
    end
  end

  always_comb begin
    set_vec            = '0;
    set_vec[FLG_TMR0]  = timer0_ovf;                    // [RQ5]
    set_vec[FLG_TMR1]  = timer1_ovf;                    // [RQ5]
    set_vec[FLG_WDT]   = wdt_timeout;                   // [RQ6]
    set_vec[FLG_T2]    = timer2_event;                  // [RQ7]
    set_vec[FLG_RX]    = uart_rx_done;
    set_vec[FLG_TX]    = uart_tx_done;
    set_vec[FLG_SI]    = (i2c_state_code != code_q);   // [RQ9]
    set_vec[FLG_I2CTO] = i2c_timeout;
    set_vec[FLG_CAP]   = capture_event;                 // [RQ10]
    set_vec[FLG_KB]    = keypad_event;
    hw_clr             = '0;
    hw_clr[FLG_TMR0]   = grant && (best_idx == flic_src_t'(SRC_TMR0));  // [RQ5]
    hw_clr[FLG_TMR1]   = grant && (best_idx == flic_src_t'(SRC_TMR1));  // [RQ5]
  end

  // Set wins over any clear in the same cycle
  for (genvar f = 0; f < NFLG; f++) begin : g_flag
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        flg_q[f] <= 1'b0;
      end else begin
        flg_q[f] <= set_vec[f] | (flg_q[f] & ~flag_sw_clear[f] & ~hw_clr[f]);  // [RQ8] [RQ10]
      end
    end
  end
  assign irq_flags = flg_q;

  // ****************************************
  // Request gating and sampling
  // ****************************************
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] req_q;
  flic_lvl_t       lvl [NSRC];

  always_comb begin
    raw           = '0;
    raw[SRC_EXT0] = ext_q[0];
    raw[SRC_BO]   = brownout_flag & brownout_irq_select;  // [RQ11]
    raw[SRC_WDT]  = flg_q[FLG_WDT];
    raw[SRC_TMR0] = flg_q[FLG_TMR0];
    raw[SRC_I2C]  = flg_q[FLG_SI] | flg_q[FLG_I2CTO];     // [RQ9]
    raw[SRC_EXT1] = ext_q[1];
    raw[SRC_KB]   = flg_q[FLG_KB];
    raw[SRC_TMR1] = flg_q[FLG_TMR1];
    raw[SRC_UART] = flg_q[FLG_RX] | flg_q[FLG_TX];        // [RQ8]
    raw[SRC_T2]   = flg_q[FLG_T2];
    raw[SRC_CAP]  = flg_q[FLG_CAP];
    en            = '0;
    en[SRC_EXT0]  = en_a_q[ENA_EXT0];                     // [RQ21]
    en[SRC_BO]    = en_b_q[ENB_BO];                       // [RQ11]
    en[SRC_WDT]   = en_b_q[ENB_WDT];                      // [RQ6]
    en[SRC_TMR0]  = en_a_q[ENA_TMR0];
    en[SRC_I2C]   = en_b_q[ENB_I2C];
    en[SRC_EXT1]  = en_a_q[ENA_EXT1];
    en[SRC_KB]    = en_b_q[ENB_KB];
    en[SRC_TMR1]  = en_a_q[ENA_TMR1];
    en[SRC_UART]  = en_a_q[ENA_UART];
    en[SRC_T2]    = en_a_q[ENA_T2];
    en[SRC_CAP]   = en_b_q[ENB_CAP];
  end

  for (genvar s = 0; s < NSRC; s++) begin : g_src
    assign lvl[s] = {pu_q[s], pl_q[s]};  // [RQ18]
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        req_q[s] <= 1'b0;
      end else if (tick_q) begin
        req_q[s] <= raw[s] & en[s] & en_a_q[ENA_GLOBAL];  // [RQ1] [RQ13] [RQ15]
      end
    end
  end

  // ****************************************
  // Priority resolution
  // ****************************************
  logic      best_found;
  flic_lvl_t best_lvl;
  logic      act_valid;
  flic_lvl_t act_lvl;

  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_lvl   = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req_q[i] && (!best_found || lvl[i] > best_lvl)) begin  // [RQ19] [RQ20]
        best_found = 1'b1;
        best_idx   = flic_src_t'(i);
        best_lvl   = lvl[i];
      end
    end
  end

  logic [3:0] isv_q;

  always_comb begin
    act_valid = |isv_q;
    act_lvl   = '0;
    for (int l = 0; l < 4; l++) begin
      if (isv_q[l]) begin
        act_lvl = flic_lvl_t'(l);
      end
    end
  end

  // ****************************************
  // Hardware call sequencer
  // ****************************************
  flic_state_e state_q;
  logic [1:0]  cnt_q;
  logic        push_q;
  logic        load_q;
  logic [15:0] vec_q;
  logic [3:0]  src_q;

  assign grant = tick_q && (state_q == FLIC_IDLE) && best_found
                 && (!act_valid || best_lvl > act_lvl)  // [RQ14] [RQ19]
                 && last_cycle && !instr_blocks;        // [RQ14]

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= FLIC_IDLE;
      cnt_q   <= 2'h0;
      push_q  <= 1'b0;
      load_q  <= 1'b0;
      vec_q   <= 16'h0000;
      src_q   <= 4'h0;
    end else begin
      push_q <= 1'b0;
      load_q <= 1'b0;
      unique case (state_q)
        FLIC_IDLE: begin
          if (grant) begin
            state_q <= FLIC_CALL;
            cnt_q   <= 2'h0;
            push_q  <= 1'b1;            // [RQ16]
            vec_q   <= VEC[best_idx];   // [RQ12]
            src_q   <= best_idx;
          end
        end
        FLIC_CALL: begin
          if (tick_q) begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == CALL_LAST) begin
              state_q <= FLIC_IDLE;     // [RQ23]
              load_q  <= 1'b1;          // [RQ12]
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // In-service tracking and returns
  // ****************************************
  logic pop_q;
  logic wake_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      isv_q  <= 4'h0;  // [RQ25]
      pop_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      pop_q  <= return_from_irq | subr_return;  // [RQ17]
      wake_q <= |(raw & en & WAKE_MASK);         // [RQ22]
      if (grant) begin
        isv_q[best_lvl] <= 1'b1;
      end else if (return_from_irq && act_valid) begin
        isv_q[act_lvl] <= 1'b0;  // [RQ17]
      end
    end
  end

  assign call_busy   = (state_q == FLIC_CALL);
  assign push_pc     = push_q;
  assign load_pc     = load_q;
  assign vector_addr = vec_q;
  assign call_src    = src_q;
  assign in_service  = isv_q;
  assign pop_pc      = pop_q;
  assign wake_req    = wake_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_edge_sets_flag: assert property (tick_q && trig_q[0] && samp_q[0] && !sync2_q[0] |=> ext_q[0])  // [RQ2]
    else $error("edge on external pin 0 did not set its flag");
  a_level_follows: assert property (tick_q && !trig_q[1] |=> ext_q[1] == !$past(sync2_q[1]))  // [RQ24]
    else $error("level mode flag does not follow pin");
  a_call_length: assert property (push_q |-> ##1 !load_q [*8] ##1 !load_q [*7] ##1 load_q)  // [RQ23]
    else $error("hardware call not four machine cycles long");
  a_call_gate: assert property (push_q |-> $past(last_cycle) && !$past(instr_blocks))  // [RQ14]
    else $error("call started outside allowed instruction slot");
  a_strict_preempt: assert property (push_q && $past(act_valid) |-> isv_q > $past(isv_q, 1) && !$past(isv_q[3]))  // [RQ19]
    else $error("preemption by equal or lower level");
  a_capture_kept: assert property (grant && best_idx == 4'(SRC_CAP) && flg_q[FLG_CAP] && !flag_sw_clear[FLG_CAP]  // [RQ10]
    |=> flg_q[FLG_CAP])
    else $error("capture flag cleared by call");
  a_i2c_state_set: assert property (i2c_state_code != code_q |=> flg_q[FLG_SI])  // [RQ9]
    else $error("new I2C state code did not set flag");
  a_return_from_irq_pops: assert property (return_from_irq && act_valid && !grant |=> pop_q && $countones(isv_q) == $countones($past(isv_q)) - 1)  // [RQ17]
    else $error("interrupt return did not close a service level");
  a_ret_keeps: assert property (subr_return && !return_from_irq && !grant |=> pop_q && $stable(isv_q))  // [RQ17]
    else $error("plain return changed service tracking");
  a_timer_hw_clear: assert property (grant && best_idx == 4'(SRC_TMR0) && !timer0_ovf |=> !flg_q[FLG_TMR0])  // [RQ5]
    else $error("timer0 flag not cleared by call");
  a_wake_source: assert property (wake_q |-> $past(ext_q[0] & en_a_q[ENA_EXT0] | ext_q[1] & en_a_q[ENA_EXT1]  // [RQ22]
    | raw[SRC_BO] & en_b_q[ENB_BO] | flg_q[FLG_WDT] & en_b_q[ENB_WDT] | flg_q[FLG_KB] & en_b_q[ENB_KB]))
    else $error("wake raised by non-waking source");

  c_edge_call: cover property (push_q && src_q == 4'(SRC_EXT0));
  c_nested: cover property (push_q && $past(act_valid));
  c_return_from_irq: cover property (return_from_irq && act_valid);
  c_tie_break: cover property (grant && $countones(req_q) > 1);

endmodule : flic_core

//--- test/flic_core_model.sv
// Behavioural core sequencer and stack facing the interrupt controller
`timescale 1ns/1ps
module flic_core_model (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        mc_tick,
  input  wire logic        push_pc,
  input  wire logic        pop_pc,
  input  wire logic        load_pc,
  input  wire logic [15:0] vector_addr,
  input  wire logic        slow,
  input  wire logic        blk,
  output logic             last_cycle,
  output logic             instr_blocks,
  output logic [3:0]       depth,
  output logic [15:0]      pc
);
  logic [1:0] mc_cnt_q;

  // ****************************************
  // Instruction timing
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mc_cnt_q <= 2'h0;
    end else if (mc_tick) begin
      mc_cnt_q <= (mc_cnt_q == 2'h2) ? 2'h0 : mc_cnt_q + 2'h1;
    end
  end
  assign last_cycle   = !slow || (mc_cnt_q == 2'h2);
  assign instr_blocks = blk;

  // ****************************************
  // Stack and program counter
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      depth <= 4'h0;
    end else if (push_pc && !pop_pc) begin
      depth <= depth + 4'h1;
    end else if (pop_pc && !push_pc) begin
      depth <= depth - 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pc <= 16'h0000;
    end else if (load_pc) begin
      pc <= vector_addr;
    end
  end
endmodule : flic_core_model

//--- test/tb_top.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_top;
  import flic_pkg::*;
  logic        sys_clk, srst, slow, blk, last_cycle, instr_blocks, brownout_flag, brownout_irq_select;
  logic        return_from_irq, subr_return, mc_tick, call_busy, push_pc, load_pc, pop_pc, wake_req;
  logic [1:0]  ext_irq_n, ext_trigger_select, ext_request_flag;
  logic [8:0]  ev;
  logic [7:0]  i2c_state_code, irq_enable_reg_a, irq_enable_reg_b;
  logic [9:0]  flag_sw_clear, irq_flags;
  logic [10:0] priority_upper_bit, priority_lower_bit;
  logic [15:0] vector_addr, pc;
  logic [3:0]  call_src, in_service, depth;
  int          miscompares, checked, cycles;
  localparam logic [15:0] VE [11] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h0013, 16'h003B,
                                      16'h001B, 16'h0023, 16'h0043, 16'h006B};
  localparam logic [7:0]  EXA [11] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h10, 8'h20, 8'h00};
  localparam logic [7:0]  EXB [11] = '{8'h00, 8'h40, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h80};
  localparam logic [9:0]  FL [11] = '{10'h000, 10'h000, 10'h004, 10'h000, 10'h040, 10'h000, 10'h200, 10'h000,
                                      10'h010, 10'h008, 10'h100};
  localparam int          EVB [11] = '{0, 0, 2, 0, 0, 0, 8, 1, 4, 3, 7};

  flic_core DUT (
    .sys_clk, .srst, .ext_irq_n, .ext_trigger_select, .timer0_ovf(ev[0]), .timer1_ovf(ev[1]),
    .wdt_timeout(ev[2]), .timer2_event(ev[3]), .uart_rx_done(ev[4]), .uart_tx_done(ev[5]), .i2c_state_code,
    .i2c_timeout(ev[6]), .capture_event(ev[7]), .keypad_event(ev[8]), .brownout_flag, .brownout_irq_select,
    .flag_sw_clear, .irq_enable_reg_a, .irq_enable_reg_b, .priority_upper_bit, .priority_lower_bit, .last_cycle,
    .instr_blocks, .return_from_irq, .subr_return, .ext_request_flag, .irq_flags, .mc_tick, .call_busy, .push_pc,
    .load_pc, .vector_addr, .call_src, .in_service, .pop_pc, .wake_req);
  flic_core_model core (.sys_clk, .srst, .mc_tick, .push_pc, .pop_pc, .load_pc, .vector_addr, .slow, .blk,
    .last_cycle, .instr_blocks, .depth, .pc);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic conclude;
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic trigger(int s);
    case (s)
      0: ext_irq_n[0] <= 1'b0;
      5: ext_irq_n[1] <= 1'b0;
      1: brownout_flag <= 1'b1;
      4: i2c_state_code <= i2c_state_code + 8'h01;
      default: ev[EVB[s]] <= 1'b1;
    endcase
    @(posedge sys_clk);
    ev <= 9'h000;
  endtask : trigger
  task automatic wait_call(logic [15:0] v, logic [3:0] s);
    int n;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (push_pc !== 1'b1 && n < 300);
    `CHK(push_pc, 1'b1)
    `CHK(vector_addr, v)
    `CHK(call_src, s)
    `CHK(call_busy, 1'b1)
    n = 0;
    do begin @(posedge sys_clk); n++; end while (load_pc !== 1'b1 && n < 40);
    `CHK(n, 16)
    @(posedge sys_clk);
    `CHK(pc, v)
  endtask : wait_call
  task automatic no_call(int n);
    int hit;
    hit = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (push_pc === 1'b1) hit++;
    end
    `CHK(hit, 0)
  endtask : no_call
  task automatic ret(logic irq, int lv);
    if (irq) return_from_irq <= 1'b1;
    else subr_return <= 1'b1;
    @(posedge sys_clk);
    return_from_irq <= 1'b0;
    subr_return <= 1'b0;
    @(posedge sys_clk);
    `CHK(pop_pc, 1'b1)
    `CHK(in_service[lv], ~irq)
  endtask : ret
  task automatic clean;
    ext_irq_n <= 2'b11;
    brownout_flag <= 1'b0;
    irq_enable_reg_a <= 8'h00;
    irq_enable_reg_b <= 8'h00;
    flag_sw_clear <= 10'h3FF;
    @(posedge sys_clk);
    flag_sw_clear <= 10'h000;
    tick(8);
  endtask : clean

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {miscompares, checked, cycles} = '0;
    {srst, slow, blk, brownout_flag, brownout_irq_select, return_from_irq, subr_return} = 7'h44;
    {ext_irq_n, ext_trigger_select, ev, i2c_state_code, flag_sw_clear} = {4'hF, 27'h0};
    {irq_enable_reg_a, irq_enable_reg_b, priority_upper_bit, priority_lower_bit} = '0;
    tick(10);
    srst <= 1'b0;
    tick(2);
    `CHK({push_pc, load_pc, call_busy, in_service, irq_flags, ext_request_flag}, 19'h0)
    for (int s = 0; s < 11; s++) begin
      irq_enable_reg_a <= 8'h80 | EXA[s];
      irq_enable_reg_b <= EXB[s];
      tick(4);
      trigger(s);
      wait_call(VE[s], 4'(s));
      `CHK(irq_flags, FL[s])
      `CHK(ext_request_flag, 2'b00)
      `CHK(depth, 4'h1)
      clean();
      ret(1'b1, 0);
      tick(8);
    end
    irq_enable_reg_a <= 8'h02;
    irq_enable_reg_b <= 8'h02;
    tick(2);
    trigger(6);
    tick(3);
    `CHK(wake_req, 1'b1)
    no_call(40);
    clean();
    irq_enable_reg_a <= 8'h02;
    tick(2);
    trigger(3);
    tick(3);
    `CHK(wake_req, 1'b0)
    no_call(40);
    clean();
    priority_upper_bit <= 11'h080;
    irq_enable_reg_a <= 8'h89;
    blk <= 1'b1;
    ext_irq_n[0] <= 1'b0;
    trigger(7);
    tick(20);
    blk <= 1'b0;
    wait_call(16'h001B, 4'h7);
    `CHK(in_service, 4'h4)
    no_call(60);
    ret(1'b1, 2);
    wait_call(16'h0003, 4'h0);
    ret(1'b1, 0);
    clean();
    priority_upper_bit <= 11'h088;
    priority_lower_bit <= 11'h088;
    irq_enable_reg_a <= 8'h8A;
    tick(4);
    ev <= 9'h003;
    tick(1);
    ev <= 9'h000;
    wait_call(16'h000B, 4'h3);
    `CHK(in_service, 4'h8)
    no_call(60);
    ret(1'b0, 3);
    no_call(60);
    ret(1'b1, 3);
    wait_call(16'h001B, 4'h7);
    ret(1'b1, 3);
    clean();
    priority_upper_bit <= 11'h000;
    priority_lower_bit <= 11'h000;
    irq_enable_reg_a <= 8'h80;
    irq_enable_reg_b <= 8'h40;
    brownout_irq_select <= 1'b0;
    brownout_flag <= 1'b1;
    no_call(40);
    brownout_irq_select <= 1'b1;
    blk <= 1'b1;
    no_call(40);
    brownout_flag <= 1'b0;
    tick(8);
    blk <= 1'b0;
    no_call(40);
    slow <= 1'b1;
    brownout_flag <= 1'b1;
    wait_call(16'h002B, 4'h1);
    clean();
    ret(1'b1, 0);
    slow <= 1'b0;
    ext_trigger_select <= 2'b01;
    irq_enable_reg_a <= 8'h84;
    tick(4);
    ext_irq_n[1] <= 1'b0;
    wait_call(16'h0013, 4'h5);
    `CHK(ext_request_flag[1], 1'b1)
    ret(1'b1, 0);
    wait_call(16'h0013, 4'h5);
    ext_irq_n[1] <= 1'b1;
    tick(12);
    `CHK(ext_request_flag[1], 1'b0)
    ret(1'b1, 0);
    conclude();
  end
endmodule : tb_top
